// *** include/display_mode_window_pkg.sv ***
// constants and types for the display mode and window control block
package display_mode_window_pkg;
    localparam int DATA_W = 8;
    localparam int ROW_W = 11;
    localparam int SETTLE_W = 21;

    localparam logic [7:0] ADDR_DISPLAY_MODE = 8'h02;
    localparam logic [7:0] ADDR_TOP_OFFSET = 8'h03;
    localparam logic [7:0] ADDR_BOTTOM_OFFSET = 8'h04;
    localparam logic [7:0] ADDR_RAMP_CTRL = 8'h05;
    localparam logic [7:0] ADDR_RAMP_CM = 8'h06;
    localparam logic [7:0] ADDR_RAMP_TRIM = 8'h07;
    localparam logic [7:0] ADDR_EXT_RAMP = 8'h08;
    localparam logic [7:0] ADDR_SPARE = 8'h09;
    localparam logic [7:0] ADDR_PIXEL_BIAS = 8'h0A;
    localparam logic [7:0] ADDR_GAMMA = 8'h0B;

    localparam logic [7:0] RESET_DISPLAY_MODE = 8'h20;
    localparam logic [7:0] DISPLAY_MODE_MASK = 8'h3F;
    localparam logic [7:0] RESET_TOP_OFFSET = 8'h06;
    localparam logic [7:0] RESET_BOTTOM_OFFSET = 8'h06;
    localparam logic [7:0] RESET_RAMP_CTRL = 8'h10;
    localparam logic [7:0] RESET_RAMP_CM = 8'h44;
    localparam logic [7:0] RESET_RAMP_TRIM = 8'h00;
    localparam logic [7:0] RESET_EXT_RAMP = 8'h20;
    localparam logic [1:0] RESET_SPARE = 2'h0;
    localparam logic [1:0] RESET_PIXEL_BIAS = 2'h1;
    localparam logic [3:0] RESET_GAMMA = 4'h8;

    localparam int BIT_DISPLAY_OFF = 5;
    localparam int BIT_STEREO = 4;
    localparam int BIT_DOUBLED = 3;
    localparam int BIT_SCAN_TYPE = 2;
    localparam int BIT_VDIR = 1;
    localparam int BIT_HDIR = 0;
    localparam int RAISE_HI = 7;
    localparam int RAISE_LO = 4;
    localparam int LOWER_HI = 3;
    localparam int LOWER_LO = 0;
    localparam int BIAS_W = 2;
    localparam int GAMMA_W = 4;
    localparam int BIT_GAMMA_RANGE = 3;
    localparam int CURRENT_HI = 2;

    localparam int PHYS_ROWS = 1036;
    localparam logic [ROW_W-1:0] LAST_PHYS_ROW = 11'h40B;
    localparam logic [ROW_W-1:0] ROW_MAX = 11'h7FF;

    localparam int PIN_VSYNC = 0;
    localparam int PIN_HSYNC = 1;
    localparam int PIN_ENABLE = 2;
    localparam int PIN_COUNT = 3;

    // serial device address, value arbitrary
    localparam logic [6:0] DEVICE_ADDR = 7'h4C;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BYTE_LAST = 4'h7;

    localparam int GAMMA_SETTLE_MS = 10;
    localparam int CLOCK_KHZ = 125000;
    localparam int GAMMA_SETTLE_COUNT = GAMMA_SETTLE_MS * CLOCK_KHZ;

    typedef enum logic [2:0] {
        SER_IDLE = 3'b000,
        SER_ADDR = 3'b001,
        SER_ACK_ADDR = 3'b010,
        SER_WRITE = 3'b011,
        SER_ACK_WRITE = 3'b100,
        SER_READ = 3'b101,
        SER_ACK_READ = 3'b110
    } serial_state_type;
endpackage

// *** src/cfg_serial_slave.sv ***
// serial configuration port slave with register pointer
`timescale 1ns/100ps
module cfg_serial_slave (
    input wire logic clock,
    input wire logic rstSync_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic [display_mode_window_pkg::DATA_W-1:0] regAddr,
    output logic [display_mode_window_pkg::DATA_W-1:0] wrData,
    output logic wrStrobe,
    input wire logic [display_mode_window_pkg::DATA_W-1:0] rdData
);
    import display_mode_window_pkg::*;

    logic [2:0] sclSync_reg;
    logic [2:0] sdaSync_reg;
    logic sclLevel_reg;
    logic sdaLevel_reg;
    logic sclNew, sdaNew, sclRise, sclFall, startSeen, stopSeen;
    serial_state_type state_reg;
    logic [DATA_W-1:0] shift_reg;
    logic [3:0] bitCount_reg;
    logic readMode_reg;
    logic pointerNext_reg;

    assign sdaOut = 1'h0;
    assign sclNew = (sclSync_reg[1] == sclSync_reg[2]) ?
                    sclSync_reg[2] : sclLevel_reg;
    assign sdaNew = (sdaSync_reg[1] == sdaSync_reg[2]) ?
                    sdaSync_reg[2] : sdaLevel_reg;
    assign sclRise = sclNew && !sclLevel_reg;
    assign sclFall = !sclNew && sclLevel_reg;
    assign startSeen = sclLevel_reg && sclNew && sdaLevel_reg && !sdaNew;
    assign stopSeen = sclLevel_reg && sclNew && !sdaLevel_reg && sdaNew;

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            sclSync_reg <= 3'h7;
            sdaSync_reg <= 3'h7;
            sclLevel_reg <= 1'h1;
            sdaLevel_reg <= 1'h1;
        end else begin
            sclSync_reg <= {sclSync_reg[1:0], sclIn};
            sdaSync_reg <= {sdaSync_reg[1:0], sdaIn};
            sclLevel_reg <= sclNew;
            sdaLevel_reg <= sdaNew;
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg <= SER_IDLE;
            shift_reg <= '0;
            bitCount_reg <= '0;
            readMode_reg <= 1'h0;
            pointerNext_reg <= 1'h0;
            sdaOe <= 1'h0;
            regAddr <= '0;
            wrData <= '0;
            wrStrobe <= 1'h0;
        end else begin
            wrStrobe <= 1'h0;
            // pointer advances after each byte written
            if (wrStrobe) begin
                regAddr <= regAddr + 8'h01;
            end
            if (startSeen) begin
                state_reg <= SER_ADDR;
                bitCount_reg <= '0;
                sdaOe <= 1'h0;
            end else if (stopSeen) begin
                state_reg <= SER_IDLE;
                sdaOe <= 1'h0;
            end else begin
                case (state_reg)
                    SER_ADDR, SER_WRITE: begin
                        if (sclRise) begin
                            shift_reg <= {shift_reg[DATA_W-2:0], sdaNew};
                            bitCount_reg <= bitCount_reg + 4'h1;
                        end else if (sclFall && bitCount_reg == BYTE_BITS) begin
                            bitCount_reg <= '0;
                            if (state_reg == SER_WRITE) begin
                                sdaOe <= 1'h1;
                                state_reg <= SER_ACK_WRITE;
                                if (pointerNext_reg) begin
                                    regAddr <= shift_reg;
                                    pointerNext_reg <= 1'h0;
                                end else begin
                                    wrData <= shift_reg;
                                    wrStrobe <= 1'h1;
                                end
                            end else if (shift_reg[DATA_W-1:1] == DEVICE_ADDR)
                            begin
                                sdaOe <= 1'h1;
                                readMode_reg <= shift_reg[0];
                                pointerNext_reg <= !shift_reg[0];
                                state_reg <= SER_ACK_ADDR;
                            end else begin
                                state_reg <= SER_IDLE;
                            end
                        end
                    end
                    SER_ACK_ADDR, SER_ACK_WRITE, SER_ACK_READ: begin
                        if (state_reg == SER_ACK_READ && sclRise && sdaNew) begin
                            state_reg <= SER_IDLE;
                        end else if (sclFall) begin
                            if (readMode_reg) begin
                                shift_reg <= rdData;
                                sdaOe <= !rdData[DATA_W-1];
                                bitCount_reg <= '0;
                                regAddr <= regAddr + 8'h01;
                                state_reg <= SER_READ;
                            end else begin
                                sdaOe <= 1'h0;
                                state_reg <= SER_WRITE;
                            end
                        end
                    end
                    SER_READ: begin
                        if (sclFall && bitCount_reg == BYTE_LAST) begin
                            sdaOe <= 1'h0;
                            state_reg <= SER_ACK_READ;
                        end else if (sclFall) begin
                            shift_reg <= {shift_reg[DATA_W-2:0], 1'h0};
                            sdaOe <= !shift_reg[DATA_W-2];
                            bitCount_reg <= bitCount_reg + 4'h1;
                        end
                    end
                    default: begin
                        sdaOe <= 1'h0;
                    end
                endcase
            end
        end
    end
endmodule

// *** src/display_mode_window_ctrl.sv ***
// display mode, scan control and active window configuration block
// What this block does
// - display-off bit resets to 1; panel stays dark until host clears it
// - stereo bit picks normal display or frame-sequential stereo scanning
// - stereo mode forces progressive scan regardless of scan-type bit
// - enable captured on VSYNC falling edge, applied to the following frame
// - inactive captured enable in stereo holds old frame, refuses new video
// - resolution bit selects doubled mode repeating each line and pixel
// - scan-type bit selects progressive at 0, interlaced at 1
// - vertical direction bit scans top-down at 0, bottom-up at 1
// - horizontal direction bit scans left-right at 0, right-left at 1
// - top and bottom offsets, reset 06, place window in 1036 rows
// - lower top or higher bottom offset moves window up equally
// - ramp trim holds raise nibble in 7-4, lower nibble in 3-0
// - pixel bias: 00 off, 01 half nanoamp at reset, 10 one nanoamp
// - gamma range bit: 0 full range, 1 half range at reset
// - gamma current: code 0 is reference over 128, doubling per code
// - enable polarity input: 0 active low, 1 active high
`timescale 1ns/100ps
module display_mode_window_ctrl #(
    parameter int GAMMA_SETTLE_CYCLES =
        display_mode_window_pkg::GAMMA_SETTLE_COUNT
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic vsyncIn,
    input wire logic hsyncIn,
    input wire logic stereoEnableIn,
    input wire logic stereoEnableActiveHigh,
    output logic panelOn,
    output logic stereoMode,
    output logic frameAccept,
    output logic holdFrame,
    output logic doubledMode,
    output logic interlacedScan,
    output logic fieldOdd,
    output logic rowReverse,
    output logic pixelReverse,
    output logic [display_mode_window_pkg::ROW_W-1:0] firstActiveRow,
    output logic [display_mode_window_pkg::ROW_W-1:0] lastActiveRow,
    output logic [display_mode_window_pkg::ROW_W-1:0] scanRow,
    output logic rowValid,
    output logic [3:0] rampMaxRaise,
    output logic [3:0] rampMaxLower,
    output logic [1:0] pixelBias,
    output logic gammaOutRange,
    output logic [2:0] gammaSenseCurrent,
    output logic gammaSettled
);
    import display_mode_window_pkg::*;

    localparam logic [SETTLE_W-1:0] SETTLE_LOAD =
        SETTLE_W'(GAMMA_SETTLE_CYCLES);

    logic [1:0] resetPipe_reg;
    logic rstSync_n;
    logic [2:0] pinSync_reg [PIN_COUNT];
    logic [PIN_COUNT-1:0] pinLevel_reg;
    logic [PIN_COUNT-1:0] pinNew;
    logic [PIN_COUNT-1:0] pinIn;
    logic vsyncFall, hsyncRise;

    logic [DATA_W-1:0] regAddr, wrData, rdData;
    logic wrStrobe;

    logic [DATA_W-1:0] displayMode_reg;
    logic [DATA_W-1:0] topOffset_reg;
    logic [DATA_W-1:0] bottomOffset_reg;
    logic [DATA_W-1:0] rampCtrl_reg;
    logic [DATA_W-1:0] ramp_cm_reserved_reg;
    logic [DATA_W-1:0] rampTrim_reg;
    logic [DATA_W-1:0] extRamp_reg;
    logic [BIAS_W-1:0] spare_reg;
    logic [BIAS_W-1:0] pixelBias_reg;
    logic [GAMMA_W-1:0] gamma_reg;

    logic enableCaptured_reg;
    logic fieldOdd_reg;
    logic [ROW_W-1:0] lineIndex_reg;
    logic [ROW_W-1:0] rowDistance;
    logic [ROW_W-1:0] windowSpan;
    logic [ROW_W-1:0] rowTarget;
    logic [ROW_W-1:0] scanRow_reg;
    logic rowValid_reg;
    logic [SETTLE_W-1:0] settleCount_reg;

    function automatic logic writeHit(input logic [DATA_W-1:0] addr);
        return wrStrobe && (regAddr == addr);
    endfunction

    function automatic logic [DATA_W-1:0] readReg(
        input logic [DATA_W-1:0] addr
    );
        logic [DATA_W-1:0] value;
        value = '0;
        if (addr == ADDR_DISPLAY_MODE) begin
            value = displayMode_reg;
        end else if (addr == ADDR_TOP_OFFSET) begin
            value = topOffset_reg;
        end else if (addr == ADDR_BOTTOM_OFFSET) begin
            value = bottomOffset_reg;
        end else if (addr == ADDR_RAMP_CTRL) begin
            value = rampCtrl_reg;
        end else if (addr == ADDR_RAMP_CM) begin
            value = ramp_cm_reserved_reg;
        end else if (addr == ADDR_RAMP_TRIM) begin
            value = rampTrim_reg;
        end else if (addr == ADDR_EXT_RAMP) begin
            value = extRamp_reg;
        end else if (addr == ADDR_SPARE) begin
            value = DATA_W'(spare_reg);
        end else if (addr == ADDR_PIXEL_BIAS) begin
            value = DATA_W'(pixelBias_reg);
        end else if (addr == ADDR_GAMMA) begin
            value = DATA_W'(gamma_reg);
        end
        return value;
    endfunction

    // reset release through two flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            resetPipe_reg <= 2'h0;
        end else begin
            resetPipe_reg <= {resetPipe_reg[0], 1'h1};
        end
    end
    assign rstSync_n = resetPipe_reg[1];

    // video pins: three flops, level moves once stages two and three agree
    assign pinIn[PIN_VSYNC] = vsyncIn;
    assign pinIn[PIN_HSYNC] = hsyncIn;
    assign pinIn[PIN_ENABLE] = stereoEnableIn;

    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        assign pinNew[i] = (pinSync_reg[i][1] == pinSync_reg[i][2]) ?
                           pinSync_reg[i][2] : pinLevel_reg[i];
        always_ff @(posedge clock or negedge rstSync_n) begin
            if (!rstSync_n) begin
                pinSync_reg[i] <= 3'h0;
                pinLevel_reg[i] <= 1'h0;
            end else begin
                pinSync_reg[i] <= {pinSync_reg[i][1:0], pinIn[i]};
                pinLevel_reg[i] <= pinNew[i];
            end
        end
    end

    assign vsyncFall = pinLevel_reg[PIN_VSYNC] && !pinNew[PIN_VSYNC];
    assign hsyncRise = !pinLevel_reg[PIN_HSYNC] && pinNew[PIN_HSYNC];

    cfg_serial_slave u_serial (
        .clock(clock),
        .rstSync_n(rstSync_n),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .regAddr(regAddr),
        .wrData(wrData),
        .wrStrobe(wrStrobe),
        .rdData(rdData)
    );

    assign rdData = readReg(regAddr);

    // register file written from the serial port
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            displayMode_reg <= RESET_DISPLAY_MODE;
            topOffset_reg <= RESET_TOP_OFFSET;
            bottomOffset_reg <= RESET_BOTTOM_OFFSET;
            rampCtrl_reg <= RESET_RAMP_CTRL;
            ramp_cm_reserved_reg <= RESET_RAMP_CM;
            rampTrim_reg <= RESET_RAMP_TRIM;
            extRamp_reg <= RESET_EXT_RAMP;
            spare_reg <= RESET_SPARE;
            pixelBias_reg <= RESET_PIXEL_BIAS;
            gamma_reg <= RESET_GAMMA;
        end else if (writeHit(ADDR_DISPLAY_MODE)) begin
            displayMode_reg <= wrData & DISPLAY_MODE_MASK;
        end else if (writeHit(ADDR_TOP_OFFSET)) begin
            topOffset_reg <= wrData;
        end else if (writeHit(ADDR_BOTTOM_OFFSET)) begin
            bottomOffset_reg <= wrData;
        end else if (writeHit(ADDR_RAMP_CTRL)) begin
            rampCtrl_reg <= wrData;
        end else if (writeHit(ADDR_RAMP_CM)) begin
            ramp_cm_reserved_reg <= wrData;
        end else if (writeHit(ADDR_RAMP_TRIM)) begin
            rampTrim_reg <= wrData;
        end else if (writeHit(ADDR_EXT_RAMP)) begin
            extRamp_reg <= wrData;
        end else if (writeHit(ADDR_SPARE)) begin
            spare_reg <= wrData[BIAS_W-1:0];
        end else if (writeHit(ADDR_PIXEL_BIAS)) begin
            pixelBias_reg <= wrData[BIAS_W-1:0];
        end else if (writeHit(ADDR_GAMMA)) begin
            gamma_reg <= wrData[GAMMA_W-1:0];
        end
    end

    // mode decode
    assign panelOn = !displayMode_reg[BIT_DISPLAY_OFF];
    assign stereoMode = displayMode_reg[BIT_STEREO];
    assign doubledMode = displayMode_reg[BIT_DOUBLED];
    assign interlacedScan = displayMode_reg[BIT_SCAN_TYPE] && !stereoMode;
    assign rowReverse = displayMode_reg[BIT_VDIR];
    assign pixelReverse = displayMode_reg[BIT_HDIR];

    assign rampMaxRaise = rampTrim_reg[RAISE_HI:RAISE_LO];
    assign rampMaxLower = rampTrim_reg[LOWER_HI:LOWER_LO];
    assign pixelBias = pixelBias_reg;
    assign gammaOutRange = gamma_reg[BIT_GAMMA_RANGE];
    assign gammaSenseCurrent = gamma_reg[CURRENT_HI:0];

    // window placement inside the physical rows
    assign firstActiveRow = ROW_W'(topOffset_reg);
    assign lastActiveRow = LAST_PHYS_ROW - ROW_W'(bottomOffset_reg);

    // stereo enable caught on vsync fall; holds for the whole next frame
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            enableCaptured_reg <= 1'h0;
        end else if (vsyncFall) begin
            enableCaptured_reg <= pinNew[PIN_ENABLE];
        end
    end

    assign frameAccept = !stereoMode ||
        (enableCaptured_reg == stereoEnableActiveHigh);
    assign holdFrame = !frameAccept;

    // field alternates per frame while interlaced
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            fieldOdd_reg <= 1'h0;
        end else if (vsyncFall) begin
            if (interlacedScan) begin
                fieldOdd_reg <= !fieldOdd_reg;
            end else begin
                fieldOdd_reg <= 1'h0;
            end
        end
    end
    assign fieldOdd = fieldOdd_reg;

    // incoming line count within the frame
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            lineIndex_reg <= '0;
        end else if (vsyncFall) begin
            lineIndex_reg <= '0;
        end else if (hsyncRise && lineIndex_reg != ROW_MAX) begin
            lineIndex_reg <= lineIndex_reg + 11'h001;
        end
    end

    // doubled lines and interlaced fields both step two rows per line
    always_comb begin
        if (doubledMode || interlacedScan) begin
            rowDistance = {lineIndex_reg[ROW_W-2:0],
                           interlacedScan && fieldOdd_reg};
        end else begin
            rowDistance = lineIndex_reg;
        end
        windowSpan = lastActiveRow - firstActiveRow;
        if (rowReverse) begin
            rowTarget = lastActiveRow - rowDistance;
        end else begin
            rowTarget = firstActiveRow + rowDistance;
        end
    end

    // row to be written for the line now arriving
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            scanRow_reg <= '0;
            rowValid_reg <= 1'h0;
        end else if (vsyncFall) begin
            rowValid_reg <= 1'h0;
        end else if (hsyncRise) begin
            scanRow_reg <= rowTarget;
            rowValid_reg <= frameAccept && panelOn &&
                            (rowDistance <= windowSpan);
        end
    end
    assign scanRow = scanRow_reg;
    assign rowValid = rowValid_reg;

    // gamma sensor settle timer, restarted by any write to its register
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            settleCount_reg <= SETTLE_LOAD;
        end else if (writeHit(ADDR_GAMMA)) begin
            settleCount_reg <= SETTLE_LOAD;
        end else if (settleCount_reg != '0) begin
            settleCount_reg <= settleCount_reg - 21'h000001;
        end
    end
    assign gammaSettled = (settleCount_reg == '0);
endmodule

// *** verif/display_mode_window_chk.sv ***
// assertion checker for the display mode and window control block
`timescale 1ns/100ps
module display_mode_window_chk (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic vsyncIn,
    input wire logic stereoEnableIn,
    input wire logic stereoEnableActiveHigh,
    input wire logic panelOn,
    input wire logic stereoMode,
    input wire logic frameAccept,
    input wire logic holdFrame,
    input wire logic interlacedScan,
    input wire logic rowValid,
    input wire logic [2:0] gammaSenseCurrent,
    input wire logic gammaSettled
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_dark; $rose(reset_n) |-> !panelOn [*8]; endproperty
    a_dark: assert property (p_dark) else $error("panel lit at reset");
    property p_hold; holdFrame == !frameAccept; endproperty
    a_hold: assert property (p_hold) else $error("hold not inverse");
    property p_prog; interlacedScan |-> !stereoMode; endproperty
    a_prog: assert property (p_prog) else $error("stereo interlaced");
    property p_norm; !stereoMode |-> frameAccept; endproperty
    a_norm: assert property (p_norm) else $error("normal frame held");
    // enable moving mid-frame must not reach the frame decision
    property p_late; $changed(stereoEnableIn) && stereoMode |-> ##1
        ($stable(frameAccept) || $changed(stereoMode)
        || $changed(stereoEnableActiveHigh)) [*8]; endproperty
    a_late: assert property (p_late) else $error("enable not held");
    property p_pol; $fell(vsyncIn) ##6 stereoMode |->
        frameAccept == (stereoEnableIn == stereoEnableActiveHigh); endproperty
    a_pol: assert property (p_pol) else $error("wrong frame pick");
    property p_lit; $rose(rowValid) |-> $past(panelOn) && $past(frameAccept);
    endproperty
    a_lit: assert property (p_lit) else $error("row while dark");
    property p_gam; $changed(gammaSenseCurrent) |-> ##[0:2] !gammaSettled;
    endproperty
    a_gam: assert property (p_gam) else $error("settle not restarted");
endmodule
bind display_mode_window_ctrl display_mode_window_chk i_chk (
    .clock, .reset_n, .vsyncIn, .stereoEnableIn, .stereoEnableActiveHigh,
    .panelOn, .stereoMode, .frameAccept, .holdFrame, .interlacedScan,
    .rowValid, .gammaSenseCurrent, .gammaSettled);

// *** verif/video_source.sv ***
// video source model: sync frames, stereo enable flips per eye
`timescale 1ns/100ps
module video_source (
    input wire logic clock,
    output logic vsync,
    output logic hsync,
    output logic enable
);
    initial begin
        vsync = 1'b1;
        hsync = 1'b0;
        enable = 1'b0;
        forever begin
            repeat (20) @(negedge clock);
            vsync = 1'b0;
            repeat (6) @(negedge clock);
            vsync = 1'b1;
            repeat (240) begin
                repeat (10) @(negedge clock);
                hsync = 1'b1;
                repeat (6) @(negedge clock);
                hsync = 1'b0;
            end
            // left eye with enable high, right eye with enable low
            enable = ~enable;
        end
    end
endmodule

// *** verif/test_display_mode_window_ctrl.sv ***
// self-checking bench for the display mode and window control block
`timescale 1ns/100ps
module test_display_mode_window_ctrl;
    import display_mode_window_pkg::*;
    logic clock, reset_n, sclIn, sdaHost, stereoEnableActiveHigh, e;
    logic sdaOut, sdaOe, vsyncIn, hsyncIn, stereoEnableIn, panelOn;
    logic stereoMode, frameAccept, holdFrame, doubledMode, fieldOdd;
    logic interlacedScan, rowReverse, pixelReverse, rowValid;
    logic gammaOutRange, gammaSettled;
    logic [ROW_W-1:0] firstActiveRow, lastActiveRow, scanRow;
    logic [3:0] rampMaxRaise, rampMaxLower;
    logic [2:0] gammaSenseCurrent;
    logic [1:0] pixelBias;
    logic [7:0] d;
    int mismatches, checked, a;
    int m[13] = '{0, 0, 'h20, 6, 6, 'h10, 'h44, 0, 'h20, 0, 1, 8, 0};
    int mk[13] = '{0, 0, 'h3F, 255, 255, 255, 255, 255, 255, 3, 3, 15, 0};
    wire logic sdaIn = sdaHost & ~sdaOe;
    wire logic [5:0] modeOut = {panelOn, stereoMode, doubledMode,
        interlacedScan, rowReverse, pixelReverse};
    wire logic [5:0] modeExp = 6'((m[2] ^ 'h20) & (m[2][4] ? 'h3B : 'h3F));
    wire logic [35:0] cfgOut = {firstActiveRow, lastActiveRow, rampMaxRaise,
        rampMaxLower, pixelBias, gammaOutRange, gammaSenseCurrent};
    wire logic [35:0] cfgExp = {11'(m[3]), 11'(PHYS_ROWS - 1 - m[4]),
        8'(m[7]), 2'(m[10]), 4'(m[11])};
    display_mode_window_ctrl #(.GAMMA_SETTLE_CYCLES(20)) i_dut (
        .clock, .reset_n, .sclIn, .sdaIn, .sdaOut, .sdaOe, .vsyncIn,
        .hsyncIn, .stereoEnableIn, .stereoEnableActiveHigh, .panelOn,
        .stereoMode, .frameAccept, .holdFrame, .doubledMode,
        .interlacedScan, .fieldOdd, .rowReverse, .pixelReverse,
        .firstActiveRow, .lastActiveRow, .scanRow, .rowValid,
        .rampMaxRaise, .rampMaxLower, .pixelBias, .gammaOutRange,
        .gammaSenseCurrent, .gammaSettled);
    video_source i_src (.clock, .vsync(vsyncIn), .hsync(hsyncIn),
        .enable(stereoEnableIn));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        #700000;
        mismatches++;
        final_report();
    end
    task automatic clk(int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(string n, logic [63:0] s, logic [63:0] x);
        checked++;
        if (s !== x) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // start is high then low, stop is low then high
    task automatic cond(logic s0, logic s1);
        clk(2);
        sdaHost = s0;
        clk(8);
        sclIn = 1'b1;
        clk(8);
        sdaHost = s1;
        clk(8);
        sclIn = s1;
    endtask
    task automatic bitx(logic b, output logic r);
        clk(2);
        sdaHost = b;
        clk(8);
        sclIn = 1'b1;
        clk(4);
        r = sdaIn;
        clk(4);
        sclIn = 1'b0;
    endtask
    task automatic xfer(logic [7:0] b, logic ck, output logic [7:0] q);
        logic k;
        for (int i = 7; i >= 0; i--) bitx(b[i], q[i]);
        bitx(1'b1, k);
        if (ck) chk("ack", k, 0);
    endtask
    // index 12 stands for an unmapped address
    task automatic acc(logic w, int r, inout logic [7:0] x);
        logic [7:0] q;
        cond(1'b1, 1'b0);
        xfer({DEVICE_ADDR, 1'b0}, 1'b1, q);
        xfer(r == 12 ? 8'h20 : 8'(r), 1'b1, q);
        if (w) xfer(x, 1'b1, q);
        else begin
            cond(1'b1, 1'b0);
            xfer({DEVICE_ADDR, 1'b1}, 1'b1, q);
            xfer(8'hFF, 1'b0, x);
        end
        cond(1'b0, 1'b1);
    endtask
    initial begin
        reset_n = 1'b0;
        sclIn = 1'b1;
        sdaHost = 1'b1;
        stereoEnableActiveHigh = 1'b0;
        void'($urandom(32'hD25B));
        repeat (6) @(posedge clock);
        clk(1);
        reset_n = 1'b1;
        clk(5);
        for (a = 1; a < 13; a++) begin
            acc(1'b0, a, d);
            chk("reset", d, m[a]);
        end
        $display("test reset values done");
        for (int r = 0; r < 24; r++) begin
            a = r % 12 + 1;
            d = 8'(a == 3 ? $urandom % 13 : a == 4 ? 12 - m[3] : $urandom);
            if (a == 5 || a == 6 || a == 8) d = 8'(m[a]);
            acc(1'b1, a, d);
            m[a] = d & mk[a];
            acc(1'b0, a, d);
            chk("readback", d, m[a]);
            chk("mode", modeOut, modeExp);
            chk("cfg", cfgOut, cfgExp);
            chk("settled", gammaSettled, 1'b1);
        end
        $display("test register access done");
        for (a = 0; a < 2; a++) begin
            d = 8'(a * 2);
            acc(1'b1, 2, d);
            @(negedge vsyncIn);
            clk(8);
            for (int i = 0; i < 99 && rowValid !== 1'b1; i++) clk(1);
            chk("scanRow", scanRow, a ? PHYS_ROWS - 1 - m[4] : m[3]);
            chk("row", {rowValid, fieldOdd}, 2'b10);
        end
        d = 8'h10;
        acc(1'b1, 2, d);
        for (a = 0; a < 4; a++) begin
            @(negedge vsyncIn);
            stereoEnableActiveHigh = a[1];
            e = stereoEnableIn;
            clk(8);
            chk("accept", frameAccept, e == a[1]);
            chk("hold", holdFrame, e != a[1]);
            clk(40);
            chk("rowValid", rowValid, e == a[1]);
        end
        $display("test video done");
        final_report();
    end
endmodule
